// *** logic/marker_cfg.svh ***
// constants for the outgoing payload marker
`ifndef MARKER_CFG_SVH
`define MARKER_CFG_SVH
`define LANES 4
`define SYNC_W 13
`define IDX_SCLK 0
`define IDX_HCLK 1
`define IDX_MODE 2
`define IDX_TEN 3
`define IDX_TBYP 4
`define IDX_IPA 5
`define IDX_FS 9
`define COL_W 11
`define STM1_COLS 11'h10e
`define STM1_TOH 11'h009
`define STM4_COLS 11'h438
`define STM4_TOH 11'h024
`define COL_ZERO 11'h000
`define COL_ONE 11'h001
`define BUF_DEPTH 2'h2
`endif

// *** logic/marker_pkg.sv ***
// types for the outgoing payload marker
package marker_pkg;
  typedef enum logic [0:0] {
    MODE_STM4 = 1'b0,
    MODE_STM1 = 1'b1
  } lane_mode_t;
endpackage : marker_pkg

// *** logic/outgoing_payload_marker.sv ***
// payload-active marker generator for the outgoing byte streams
`timescale 1ns/1ps
`include "marker_cfg.svh"
module outgoing_payload_marker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic system_clock_19m,
  input wire logic high_speed_clock_77m,
  input wire logic outgoing_lane_mode_select,
  input wire logic tributary_processing_enable,
  input wire logic tributary_group_bypass,
  input wire logic [3:0] incoming_payload_active,
  input wire logic [3:0] frame_start,
  input wire logic marker_ready,
  output logic marker_valid,
  output logic [3:0] outgoing_payload_active
);
  logic rsync1_n_ff;
  logic rst_n_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsync1_n_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rsync1_n_ff <= 1'b1;
      rst_n_ff <= rsync1_n_ff;
    end
  end

  // pin sampling: three stages, accepted once stages two and three agree
  logic [`SYNC_W-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
  logic [1:0] prv_ff, nxt_prv;
  always_comb begin
    nxt_prv = {flt_ff[`IDX_HCLK], flt_ff[`IDX_SCLK]};
    for (int b = 0; b < `SYNC_W; b++) begin
      nxt_flt[b] = (s2_ff[b] == s3_ff[b]) ? s3_ff[b] : flt_ff[b];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      flt_ff <= '0;
      prv_ff <= 2'h0;
    end else begin
      s1_ff <= {frame_start, incoming_payload_active,
                tributary_group_bypass, tributary_processing_enable,
                outgoing_lane_mode_select, high_speed_clock_77m,
                system_clock_19m};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= nxt_flt;
      prv_ff <= nxt_prv;
    end
  end

  marker_pkg::lane_mode_t mode;
  logic sclk_edge, hclk_edge, tick, bypass, in_ready, push;
  logic [3:0] word;
  assign mode = marker_pkg::lane_mode_t'(flt_ff[`IDX_MODE]);
  assign sclk_edge = flt_ff[`IDX_SCLK] & ~prv_ff[0];
  assign hclk_edge = flt_ff[`IDX_HCLK] & ~prv_ff[1];
  assign tick = (mode == marker_pkg::MODE_STM1) ? sclk_edge : hclk_edge;
  assign bypass = ~flt_ff[`IDX_TEN] | flt_ff[`IDX_TBYP];
  // a full buffer holds the column counters, so no byte position is skipped
  assign push = tick & in_ready;

  logic [`COL_W-1:0] col_ff [`LANES];
  genvar g;
  generate
    for (g = 0; g < `LANES; g++) begin : g_lane
      logic active;
      logic [`COL_W-1:0] cols, toh, nxt_col;
      assign active = (mode == marker_pkg::MODE_STM1) || (g == 0);
      assign cols = (mode == marker_pkg::MODE_STM1) ? `STM1_COLS : `STM4_COLS;
      assign toh = (mode == marker_pkg::MODE_STM1) ? `STM1_TOH : `STM4_TOH;
      always_comb begin
        nxt_col = col_ff[g];
        word[g] = 1'b0;
        if (active) begin
          if (bypass) begin
            word[g] = flt_ff[`IDX_IPA+g];
          end else begin
            word[g] = (nxt_col >= toh);
          end
        end
        if (push && active) begin
          if (flt_ff[`IDX_FS+g] || col_ff[g] == cols - `COL_ONE) begin
            nxt_col = `COL_ZERO;
          end else begin
            nxt_col = col_ff[g] + `COL_ONE;
          end
        end
      end
      always_ff @(posedge core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          col_ff[g] <= `COL_ZERO;
        end else begin
          col_ff[g] <= nxt_col;
        end
      end
    end
  endgenerate

  // two-entry buffer toward the framer
  logic [3:0] buf_ff [2];
  logic [3:0] nxt_buf [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic nxt_valid, pop;
  assign in_ready = (cnt_ff != `BUF_DEPTH);
  assign pop = marker_valid & marker_ready;
  always_comb begin
    nxt_buf[0] = buf_ff[0];
    nxt_buf[1] = buf_ff[1];
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_cnt = cnt_ff - 2'h1;
    end
    if (push) begin
      nxt_buf[nxt_cnt[0]] = word;
      nxt_cnt = nxt_cnt + 2'h1;
    end
    nxt_valid = (nxt_cnt != 2'h0);
  end
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      buf_ff[0] <= 4'h0;
      buf_ff[1] <= 4'h0;
      cnt_ff <= 2'h0;
      marker_valid <= 1'b0;
      outgoing_payload_active <= 4'h0;
    end else begin
      buf_ff[0] <= nxt_buf[0];
      buf_ff[1] <= nxt_buf[1];
      cnt_ff <= nxt_cnt;
      marker_valid <= nxt_valid;
      outgoing_payload_active <= nxt_buf[0];
    end
  end

  property p_overhead_low;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && !bypass && col_ff[0] == `COL_ONE |-> !word[0];
  endproperty
  a_overhead_low: assert property (p_overhead_low)
    else $error("marker high on an overhead byte");

  property p_bypass_copy;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && bypass && mode == marker_pkg::MODE_STM1
      |-> word == flt_ff[`IDX_IPA+3:`IDX_IPA];
  endproperty
  a_bypass_copy: assert property (p_bypass_copy)
    else $error("bypass marker differs from input");

  // counters must not move between system clock edges in four-stream mode
  property p_stm1_edge;
    @(posedge core_clk) disable iff (!rst_n_ff)
    mode == marker_pkg::MODE_STM1 && !sclk_edge
      |=> $stable(col_ff[0]) && $stable(col_ff[3]);
  endproperty
  a_stm1_edge: assert property (p_stm1_edge)
    else $error("four-stream marker moved off system clock");

  property p_stm4_edge;
    @(posedge core_clk) disable iff (!rst_n_ff)
    mode == marker_pkg::MODE_STM4 && !hclk_edge
      |=> $stable(col_ff[0]) && $stable(col_ff[1]);
  endproperty
  a_stm4_edge: assert property (p_stm4_edge)
    else $error("wide-stream marker moved off fast clock");

  property p_stm4_idle;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && mode == marker_pkg::MODE_STM4 |-> word[3:1] == 3'h0;
  endproperty
  a_stm4_idle: assert property (p_stm4_idle)
    else $error("unused markers not quiet");

  property p_stm4_wrap;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && mode == marker_pkg::MODE_STM4 && $stable(mode)
      && col_ff[0] == `STM4_COLS - `COL_ONE |=> col_ff[0] == `COL_ZERO;
  endproperty
  a_stm4_wrap: assert property (p_stm4_wrap)
    else $error("wide-stream row length wrong");

  property p_buf_out;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && cnt_ff == 2'h0 |=> marker_valid
      && outgoing_payload_active == $past(word);
  endproperty
  a_buf_out: assert property (p_buf_out)
    else $error("marker word not presented");

  // a stalled receiver must see the same head word on the next edge
  property p_buf_hold;
    @(posedge core_clk) disable iff (!rst_n_ff)
    marker_valid && !marker_ready
      |=> marker_valid && $stable(outgoing_payload_active);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("stalled marker word changed");

  property p_frame_restart;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && flt_ff[`IDX_FS] |=> col_ff[0] == `COL_ZERO;
  endproperty
  a_frame_restart: assert property (p_frame_restart)
    else $error("frame start did not restart the row");

  property p_stm1_wrap;
    @(posedge core_clk) disable iff (!rst_n_ff)
    push && mode == marker_pkg::MODE_STM1
      && col_ff[1] == `STM1_COLS - `COL_ONE |=> col_ff[1] == `COL_ZERO;
  endproperty
  a_stm1_wrap: assert property (p_stm1_wrap)
    else $error("stream two row length wrong");
endmodule : outgoing_payload_marker

// *** tb/marker_sink.sv ***
// downstream receiver model that counts popped words
`timescale 1ns/1ps
module marker_sink (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic marker_valid,
  input wire logic [3:0] outgoing_payload_active,
  output logic marker_ready,
  output logic [15:0] words,
  output logic [3:0][15:0] ones
);
  logic [2:0] ph_ff;
  // ready two edges of eight: stalls, yet drains between ticks
  assign marker_ready = ph_ff[2] & ph_ff[0];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ph_ff <= 3'h0;
      words <= 16'h0000;
      ones <= '0;
    end else begin
      ph_ff <= ph_ff + 3'h1;
      if (clr) begin
        words <= 16'h0000;
        ones <= '0;
      end else if (marker_valid && marker_ready) begin
        words <= words + 16'h0001;
        for (int i = 0; i < 4; i++)
          ones[i] <= ones[i] + {15'h0000, outgoing_payload_active[i]};
      end
    end
  end
endmodule : marker_sink

// *** tb/outgoing_payload_marker_tb_top.sv ***
// bench for the outgoing payload marker
`timescale 1ns/1ps
module outgoing_payload_marker_tb_top;
  logic core_clk, rstn, sclk, hclk, mode, ten, tbyp, clr, rdy, vld;
  logic [3:0] ipa, fs, opa;
  logic [15:0] words;
  logic [3:0][15:0] ones;
  int err_count, checks_done;
  outgoing_payload_marker i_outgoing_payload_marker (
    .core_clk(core_clk), .rstn(rstn), .system_clock_19m(sclk),
    .high_speed_clock_77m(hclk), .outgoing_lane_mode_select(mode),
    .tributary_processing_enable(ten), .tributary_group_bypass(tbyp),
    .incoming_payload_active(ipa), .frame_start(fs), .marker_ready(rdy),
    .marker_valid(vld), .outgoing_payload_active(opa));
  marker_sink i_marker_sink (.core_clk(core_clk), .rstn(rstn), .clr(clr),
    .marker_valid(vld), .outgoing_payload_active(opa),
    .marker_ready(rdy), .words(words), .ones(ones));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic tick();
    if (mode) sclk = 1'b1;
    else hclk = 1'b1;
    step(8);
    sclk = 1'b0;
    hclk = 1'b0;
    step(8);
  endtask : tick
  // one framing tick, then n counted ticks of the current mode
  task automatic judge(input int n, input logic [3:0][15:0] exp);
    fs = 4'hf;
    tick();
    fs = 4'h0;
    step(40);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    repeat (n) tick();
    step(40);
    checks_done++;
    if (words !== n[15:0]) begin
      err_count++;
      $display("FAIL words expected %h seen %h", n[15:0], words);
    end
    for (int i = 0; i < 4; i++) begin
      checks_done++;
      if (ones[i] !== exp[i]) begin
        err_count++;
        $display("FAIL ones %0d expected %h seen %h", i, exp[i], ones[i]);
      end
    end
    checks_done++;
    if (vld !== 1'b0) begin
      err_count++;
      $display("FAIL marker_valid expected 0 seen %b", vld);
    end
  endtask : judge
  task automatic run_stm1_payload();
    judge(270, {4{16'h0105}});
  endtask : run_stm1_payload
  task automatic run_disabled_copy();
    ten = 1'b0;
    ipa = 4'ha;
    judge(20, {16'h0014, 16'h0000, 16'h0014, 16'h0000});
  endtask : run_disabled_copy
  task automatic run_bypass_copy();
    ten = 1'b1;
    tbyp = 1'b1;
    ipa = 4'h5;
    judge(20, {16'h0000, 16'h0014, 16'h0000, 16'h0014});
  endtask : run_bypass_copy
  task automatic run_stm4_payload();
    tbyp = 1'b0;
    mode = 1'b0;
    judge(1080, {48'h0, 16'h0414});
  endtask : run_stm4_payload
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    {rstn, sclk, hclk, tbyp, clr} = 5'h00;
    {mode, ten} = 2'h3;
    ipa = 4'h0;
    fs = 4'h0;
    err_count = 0;
    checks_done = 0;
    step(5);
    rstn = 1'b1;
    step(10);
    run_stm1_payload();
    run_disabled_copy();
    run_bypass_copy();
    run_stm4_payload();
    complete_run();
  end
endmodule : outgoing_payload_marker_tb_top
